// >>> logic/dsm_pkg.sv
// constants shared by the draw-and-step and mask scissor logic
package dsm_pkg;

  // step register: four codes, one per byte
  localparam int DSM_CODES = 4;
  localparam int DSM_CODE_W = 8;
  localparam int DSM_STEP_W = 32;
  localparam logic [1:0] DSM_LAST_IDX = 2'h3;

  // step code field layout
  localparam int DSM_DIR_MSB = 7;
  localparam int DSM_DIR_LSB = 5;
  localparam int DSM_MD_BIT = 4;
  localparam int DSM_CNT_MSB = 3;
  localparam int DSM_CNT_LSB = 0;
  localparam logic [7:0] DSM_STOP_CODE = 8'h00;

  // operation register function field
  localparam int DSM_FUNC_W = 4;
  localparam logic [3:0] DSM_FUNC_DRAW_STEP = 4'h3;

  // mask map modes
  localparam logic [1:0] DSM_MASK_OFF = 2'h0;
  localparam logic [1:0] DSM_MASK_BOUND = 2'h1;
  localparam logic [1:0] DSM_MASK_FULL = 2'h2;

  // drawing modes for end pixels
  localparam logic [1:0] DSM_DRAW_NORMAL = 2'h0;
  localparam logic [1:0] DSM_DRAW_FIRST_NULL = 2'h1;
  localparam logic [1:0] DSM_DRAW_LAST_NULL = 2'h2;

  // pointer and map widths
  localparam int DSM_PTR_W = 16;
  localparam int DSM_DIM_W = 12;
  localparam int DSM_ADDR_W = 32;
  localparam int DSM_BITOFF_W = 26;

  // pointer and step counter reset values
  localparam logic [15:0] DSM_PTR_RST = 16'h0000;
  localparam logic [3:0] DSM_CNT_RST = 4'h0;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    DSM_S_IDLE = 4'b0001,
    DSM_S_PIXEL = 4'b0010,
    DSM_S_FETCH = 4'b0100,
    DSM_S_ADV = 4'b1000
  } dsm_state_t;

endpackage

// >>> logic/dsm_scissor.sv
// destination and mask map scissor tests plus mask bit address
`timescale 1ns/100ps
module dsm_scissor
  import dsm_pkg::*;
(
  // current destination pointer
  input wire logic signed [dsm_pkg::DSM_PTR_W-1:0] i_x,
  input wire logic signed [dsm_pkg::DSM_PTR_W-1:0] i_y,
  // map description
  input wire logic [1:0] i_mask_mode,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_dst_wmax,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_dst_hmax,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_mask_wmax,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_mask_hmax,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_mask_offx,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_mask_offy,
  input wire logic [dsm_pkg::DSM_ADDR_W-1:0] i_mask_base,
  // results
  output logic o_dst_ok,
  output logic o_box_ok,
  output logic o_need_fetch,
  output logic [dsm_pkg::DSM_ADDR_W-1:0] o_mask_addr,
  output logic [2:0] o_mask_bit
);
  logic signed [DSM_PTR_W-1:0] mx;
  logic signed [DSM_PTR_W-1:0] my;
  logic mask_in;
  logic [DSM_BITOFF_W-1:0] bitoff;

  // destination boundary, always on; edge pixels count as inside
  assign o_dst_ok = !i_x[DSM_PTR_W-1] && !i_y[DSM_PTR_W-1]
    && (i_x[DSM_PTR_W-2:0] <= {3'h0, i_dst_wmax})
    && (i_y[DSM_PTR_W-2:0] <= {3'h0, i_dst_hmax});

  // mask uses destination pointers less the origin offsets
  assign mx = i_x - $signed({4'h0, i_mask_offx});
  assign my = i_y - $signed({4'h0, i_mask_offy});

  // mask map may be smaller than the destination
  assign mask_in = !mx[DSM_PTR_W-1] && !my[DSM_PTR_W-1]
    && (mx[DSM_PTR_W-2:0] <= {3'h0, i_mask_wmax})
    && (my[DSM_PTR_W-2:0] <= {3'h0, i_mask_hmax});

  // full mode uses both the mask boundary and its contents
  assign o_box_ok = (i_mask_mode == DSM_MASK_OFF) ? 1'b1 : mask_in;
  assign o_need_fetch = (i_mask_mode == DSM_MASK_FULL) && mask_in;

  // one bit per pixel, row pitch is mask width in bits
  assign bitoff = DSM_BITOFF_W'(my[DSM_DIM_W-1:0] * ({1'b0, i_mask_wmax} + 13'h0001))
    + DSM_BITOFF_W'(mx[DSM_DIM_W-1:0]);
  assign o_mask_addr = i_mask_base + DSM_ADDR_W'(bitoff[DSM_BITOFF_W-1:3]);
  assign o_mask_bit = bitoff[2:0];

endmodule

// >>> logic/dsm_draw_step.sv
// draw-and-step sequencer with destination and mask map scissoring
//
// Notes on behaviour
// - Full mask mode scissors by mask rectangle and by per-pixel mask contents.
// - In full mode fetch the mask pixel first; a 0 suppresses the update.
// - A mask pixel of 1 lets the update proceed, other checks still apply.
// - Mask storage is one bit per pixel whatever the destination depth.
// - Mask may be smaller than destination; base, width, height locate it.
// - Each action draws at the pointer, then steps to one of eight neighbours.
// - Each 8-bit code gives up to 15 moves in one direction.
// - Count 0..15; one more pixel is attempted than the count.
// - Pointers end on the last attempted pixel, even if it was nulled.
// - Move-or-draw bit 1 draws pixels; 0 only moves the pointers.
// - Up to four codes per write, low byte first, one operation overall.
// - First and last pixel null treat each code as its own line.
// - Writing the top byte of the step register starts the operation.
// - Writing the operation register only latches parameters, never starts.
// - Step writes are ignored unless the function is draw-and-step.
// - Code 00 stops after it executes; higher bytes are skipped.
// - Completion, stop code included, clears the busy bit.
// - Pixels outside the destination are never updated; pointers still move.
// - Mask is addressed by destination pointers less the mask origin offsets.
`timescale 1ns/100ps
module dsm_draw_step
  import dsm_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // operation register fields
  input wire logic [dsm_pkg::DSM_FUNC_W-1:0] i_op_func,
  input wire logic [1:0] i_op_mask_mode,
  input wire logic [1:0] i_op_draw_mode,
  // step register write port
  input wire logic i_step_wr,
  input wire logic [dsm_pkg::DSM_CODES-1:0] i_step_be,
  input wire logic [dsm_pkg::DSM_STEP_W-1:0] i_step_data,
  // destination pointer load
  input wire logic i_ptr_ld,
  input wire logic [dsm_pkg::DSM_PTR_W-1:0] i_ptr_x,
  input wire logic [dsm_pkg::DSM_PTR_W-1:0] i_ptr_y,
  // destination and mask map description
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_dst_wmax,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_dst_hmax,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_mask_wmax,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_mask_hmax,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_mask_offx,
  input wire logic [dsm_pkg::DSM_DIM_W-1:0] i_mask_offy,
  input wire logic [dsm_pkg::DSM_ADDR_W-1:0] i_mask_base,
  // mask pixel fetch
  output logic o_mask_req,
  output logic [dsm_pkg::DSM_ADDR_W-1:0] o_mask_addr,
  output logic [2:0] o_mask_bit,
  input wire logic i_mask_ack,
  input wire logic i_mask_val,
  // destination pixel update
  output logic o_pix_wr,
  output logic [dsm_pkg::DSM_PTR_W-1:0] o_pix_x,
  output logic [dsm_pkg::DSM_PTR_W-1:0] o_pix_y,
  // status
  output logic o_busy,
  output logic [dsm_pkg::DSM_PTR_W-1:0] o_dst_x,
  output logic [dsm_pkg::DSM_PTR_W-1:0] o_dst_y
);
  import dsm_pkg::*;

  // sequencer state
  dsm_state_t state_ff, nxt_state;
  logic [DSM_STEP_W-1:0] codes_ff, nxt_codes;
  logic [1:0] idx_ff, nxt_idx;
  logic [3:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;
  logic [DSM_PTR_W-1:0] x_ff, nxt_x;
  logic [DSM_PTR_W-1:0] y_ff, nxt_y;

  // outward request registers
  logic mask_req_ff, nxt_mask_req;
  logic [DSM_ADDR_W-1:0] mask_addr_ff, nxt_mask_addr;
  logic [2:0] mask_bit_ff, nxt_mask_bit;
  logic pix_wr_ff, nxt_pix_wr;
  logic [DSM_PTR_W-1:0] pix_x_ff, nxt_pix_x;
  logic [DSM_PTR_W-1:0] pix_y_ff, nxt_pix_y;

  // decoded current code and scissor results
  logic [DSM_CODE_W-1:0] cur_code;
  logic [2:0] cur_dir;
  logic cur_md;
  logic [3:0] cur_cnt;
  logic end_null;
  logic dst_ok;
  logic box_ok;
  logic need_fetch;
  logic [DSM_ADDR_W-1:0] sc_addr;
  logic [2:0] sc_bit;
  logic start_ok;
  logic [1:0] first_idx;
  logic signed [1:0] dx;
  logic signed [1:0] dy;

  // lowest enabled byte of a step write, so upper-only writes run as written
  function automatic logic [1:0] low_byte(input logic [DSM_CODES-1:0] be);
    logic [1:0] r;
    r = DSM_LAST_IDX;
    for (int i = DSM_CODES - 1; i >= 0; i--) begin
      if (be[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // neighbour offsets; 0 is +x, going anticlockwise, y grows downward
  always_comb begin
    unique case (cur_dir)
      3'h0: begin dx = 2'sd1; dy = 2'sd0; end
      3'h1: begin dx = 2'sd1; dy = -2'sd1; end
      3'h2: begin dx = 2'sd0; dy = -2'sd1; end
      3'h3: begin dx = -2'sd1; dy = -2'sd1; end
      3'h4: begin dx = -2'sd1; dy = 2'sd0; end
      3'h5: begin dx = -2'sd1; dy = 2'sd1; end
      3'h6: begin dx = 2'sd0; dy = 2'sd1; end
      3'h7: begin dx = 2'sd1; dy = 2'sd1; end
    endcase
  end

  // field split of the code in flight
  assign cur_code = codes_ff[idx_ff*DSM_CODE_W +: DSM_CODE_W];
  assign cur_dir = cur_code[DSM_DIR_MSB:DSM_DIR_LSB];
  assign cur_md = cur_code[DSM_MD_BIT];
  assign cur_cnt = cur_code[DSM_CNT_MSB:DSM_CNT_LSB];

  // end pixels are judged per code, so counter restarts each code
  assign end_null = ((i_op_draw_mode == DSM_DRAW_FIRST_NULL) && (cnt_ff == DSM_CNT_RST))
    || ((i_op_draw_mode == DSM_DRAW_LAST_NULL) && (cnt_ff == cur_cnt));

  // start on top byte write; operation register alone never starts
  // other functions make the step write a no-op
  assign start_ok = i_step_wr && i_step_be[DSM_CODES-1] && (i_op_func == DSM_FUNC_DRAW_STEP);
  assign first_idx = low_byte(i_step_be);

  // scissor checks on the current pointer
  dsm_scissor u_scissor (
    .i_x(x_ff),
    .i_y(y_ff),
    .i_mask_mode(i_op_mask_mode),
    .i_dst_wmax(i_dst_wmax),
    .i_dst_hmax(i_dst_hmax),
    .i_mask_wmax(i_mask_wmax),
    .i_mask_hmax(i_mask_hmax),
    .i_mask_offx(i_mask_offx),
    .i_mask_offy(i_mask_offy),
    .i_mask_base(i_mask_base),
    .o_dst_ok(dst_ok),
    .o_box_ok(box_ok),
    .o_need_fetch(need_fetch),
    .o_mask_addr(sc_addr),
    .o_mask_bit(sc_bit)
  );

  // next-state logic of the sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_codes = codes_ff;
    nxt_idx = idx_ff;
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_x = x_ff;
    nxt_y = y_ff;
    nxt_mask_req = mask_req_ff;
    nxt_mask_addr = mask_addr_ff;
    nxt_mask_bit = mask_bit_ff;
    nxt_pix_wr = 1'b0;
    nxt_pix_x = pix_x_ff;
    nxt_pix_y = pix_y_ff;
    unique case (state_ff)
      DSM_S_IDLE: begin
        // pointer loads are only taken while no operation runs
        // a load and a start in one cycle both act, so the run uses the new pointer
        if (i_ptr_ld) begin
          nxt_x = i_ptr_x;
          nxt_y = i_ptr_y;
        end
        if (start_ok) begin
          // whole group latched at once, run from the low byte up
          nxt_codes = i_step_data;
          nxt_idx = first_idx;
          nxt_cnt = DSM_CNT_RST;
          nxt_busy = 1'b1;
          nxt_state = DSM_S_PIXEL;
        end
      end
      DSM_S_PIXEL: begin
        // pixel decision uses the pointer as it stands, before any move
        nxt_state = DSM_S_ADV;
        // move-only codes never touch the destination
        // outside the destination the update is dropped
        if (cur_md && !end_null && dst_ok && box_ok) begin
          if (need_fetch) begin
            // mask pixel fetched before the update is decided
            nxt_mask_req = 1'b1;
            nxt_mask_addr = sc_addr;
            nxt_mask_bit = sc_bit;
            nxt_state = DSM_S_FETCH;
          end else begin
            nxt_pix_wr = 1'b1;
            nxt_pix_x = x_ff;
            nxt_pix_y = y_ff;
          end
        end
      end
      DSM_S_FETCH: begin
        // request holds until the memory side answers
        // no timeout: a memory side that never answers stalls the operation
        if (i_mask_ack) begin
          nxt_mask_req = 1'b0;
          // a set mask bit lets the update through; clear drops it
          nxt_pix_wr = i_mask_val;
          nxt_pix_x = x_ff;
          nxt_pix_y = y_ff;
          nxt_state = DSM_S_ADV;
        end
      end
      DSM_S_ADV: begin
        if (cnt_ff != cur_cnt) begin
          // count+1 pixels; one fixed direction per code
          // pointer moves only after the pixel was handled
          nxt_x = x_ff + DSM_PTR_W'(dx);
          nxt_y = y_ff + DSM_PTR_W'(dy);
          nxt_cnt = cnt_ff + 4'h1;
          nxt_state = DSM_S_PIXEL;
        end else if ((cur_code == DSM_STOP_CODE) || (idx_ff == DSM_LAST_IDX)) begin
          // pointers stay on the last attempted pixel
          // stop code ends the group; busy drops on completion
          nxt_busy = 1'b0;
          nxt_state = DSM_S_IDLE;
        end else begin
          // next byte of the same operation
          nxt_idx = idx_ff + 2'h1;
          nxt_cnt = DSM_CNT_RST;
          nxt_state = DSM_S_PIXEL;
        end
      end
    endcase
  end

  // sequencer registers
  // codes are latched whole, so writes refused while busy cannot alter a run
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= DSM_S_IDLE;
      codes_ff <= 32'h0000_0000;
      idx_ff <= 2'h0;
      cnt_ff <= DSM_CNT_RST;
      busy_ff <= 1'b0;
      x_ff <= DSM_PTR_RST;
      y_ff <= DSM_PTR_RST;
    end else begin
      state_ff <= nxt_state;
      codes_ff <= nxt_codes;
      idx_ff <= nxt_idx;
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      x_ff <= nxt_x;
      y_ff <= nxt_y;
    end
  end

  // outward request registers; pixel strobe lasts one cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_req_ff <= 1'b0;
      mask_addr_ff <= 32'h0000_0000;
      mask_bit_ff <= 3'h0;
      pix_wr_ff <= 1'b0;
      pix_x_ff <= DSM_PTR_RST;
      pix_y_ff <= DSM_PTR_RST;
    end else begin
      mask_req_ff <= nxt_mask_req;
      mask_addr_ff <= nxt_mask_addr;
      mask_bit_ff <= nxt_mask_bit;
      pix_wr_ff <= nxt_pix_wr;
      pix_x_ff <= nxt_pix_x;
      pix_y_ff <= nxt_pix_y;
    end
  end

  // outputs straight from flops
  assign o_mask_req = mask_req_ff;
  assign o_mask_addr = mask_addr_ff;
  assign o_mask_bit = mask_bit_ff;
  assign o_pix_wr = pix_wr_ff;
  assign o_pix_x = pix_x_ff;
  assign o_pix_y = pix_y_ff;
  assign o_busy = busy_ff;
  assign o_dst_x = x_ff;
  assign o_dst_y = y_ff;

endmodule

// >>> tb/dsm_draw_step_sva.sv
// port assertions for the draw-and-step sequencer
`timescale 1ns/100ps
module dsm_draw_step_sva
  import dsm_pkg::*;
(
  // clock, reset and controls
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_op_func,
  input wire logic [1:0] i_op_mask_mode,
  input wire logic i_step_wr,
  input wire logic [3:0] i_step_be,
  input wire logic [31:0] i_step_data,
  input wire logic [11:0] i_dst_wmax,
  input wire logic i_mask_ack,
  input wire logic i_mask_val,
  // observed outputs
  input wire logic o_mask_req,
  input wire logic [31:0] o_mask_addr,
  input wire logic o_pix_wr,
  input wire logic [15:0] o_pix_x,
  input wire logic o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // an accepted start, then a lone stop code
  sequence s_go;
    !o_busy && i_step_wr && i_step_be[3] && i_op_func == DSM_FUNC_DRAW_STEP;
  endsequence
  sequence s_stop;
    s_go ##0 i_step_be == 4'hF && i_step_data[7:0] == DSM_STOP_CODE && i_op_mask_mode != DSM_MASK_FULL;
  endsequence
  a_busy_start: assert property (s_go |=> o_busy) else $error("no busy after start");
  a_func_other: assert property (!o_busy && i_step_wr && i_op_func != DSM_FUNC_DRAW_STEP |=> !o_busy)
    else $error("start with wrong function");
  a_top_byte: assert property (!o_busy && i_step_wr && !i_step_be[3] |=> !o_busy)
    else $error("start without top byte");
  a_stop_code: assert property (s_stop |=> o_busy ##1 (!o_pix_wr)[*2] ##[0:3] !o_busy)
    else $error("stop code did not end");
  a_pix_busy: assert property (o_pix_wr |-> o_busy) else $error("pixel outside operation");
  a_pix_dst: assert property (o_pix_wr |-> !o_pix_x[15] && o_pix_x[14:0] <= {3'h0, i_dst_wmax})
    else $error("pixel outside destination");
  a_req_hold: assert property (o_mask_req && !i_mask_ack |=> o_mask_req && $stable(o_mask_addr))
    else $error("mask fetch not held");
  a_req_drop: assert property (o_mask_req && i_mask_ack |=> !o_mask_req) else $error("mask req stuck");
  a_mask_zero: assert property (o_mask_req && i_mask_ack && !i_mask_val |=> (!o_pix_wr)[*2])
    else $error("masked pixel written");
  a_fetch_full: assert property (o_mask_req |-> i_op_mask_mode == DSM_MASK_FULL)
    else $error("fetch outside full mode");
endmodule
bind dsm_draw_step dsm_draw_step_sva u_sva (.*);

// >>> tb/dsm_draw_step_test.sv
// self-checking bench for the draw-and-step sequencer
`timescale 1ns/100ps
module dsm_draw_step_test;
  import dsm_pkg::*;
  logic i_clk = 0, i_rst_b = 0, i_step_wr = 0, i_ptr_ld = 0, i_mask_ack = 0, i_mask_val = 0;
  // function set before any step write
  logic [3:0] i_op_func = 4'h3, i_step_be = 4'hF;
  logic [1:0] i_op_mask_mode = 2'h0, i_op_draw_mode = 2'h0;
  // mask map described from time zero
  logic [31:0] i_step_data = 32'h0, i_mask_base = 32'h1000, seed = 32'hCAA4;
  logic [15:0] i_ptr_x = 16'h0, i_ptr_y = 16'h0;
  logic [11:0] i_dst_wmax = 12'h28, i_dst_hmax = 12'h1E, i_mask_wmax = 12'h14, i_mask_hmax = 12'hF;
  logic [11:0] i_mask_offx = 12'h5, i_mask_offy = 12'h4;
  wire o_mask_req, o_pix_wr, o_busy;
  wire [31:0] o_mask_addr;
  wire [2:0] o_mask_bit;
  wire [15:0] o_pix_x, o_pix_y, o_dst_x, o_dst_y;
  int bad_count = 0, n_tests = 0, ex, ey;
  int DX[8] = '{1, 1, 0, -1, -1, -1, 0, 1};
  int DY[8] = '{0, -1, -1, -1, 0, 1, 1, 1};
  // partial writes fill the upper bytes
  logic [3:0] BE[4] = '{4'hF, 4'hE, 4'hC, 4'h8};
  logic [31:0] q[$];
  dsm_draw_step DUT (.*);
  initial forever #25 i_clk = ~i_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // mask contents seen by the fetch responder
  function automatic logic mf(input logic [15:0] x, input logic [15:0] y);
    return x[0] ^ y[1];
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // expected pixel list: each code a line, low byte first, stop on 00
  task automatic predict(input logic [31:0] d, input logic [3:0] be);
    logic [7:0] c;
    bit ok, st;
    st = 0;
    for (int b = 0; b < 4; b++) begin
      c = d[8*b+:8];
      if (be[b] && !st) begin
        for (int i = 0; i <= c[3:0]; i++) begin
          ok = c[4] && !(i_op_draw_mode == 2'h1 && i == 0) && !(i_op_draw_mode == 2'h2 && i == c[3:0]);
          ok &= ex >= 0 && ey >= 0 && ex <= int'(i_dst_wmax) && ey <= int'(i_dst_hmax);
          if (i_op_mask_mode != DSM_MASK_OFF) ok &= ex >= int'(i_mask_offx) && ey >= int'(i_mask_offy)
            && ex <= int'(i_mask_offx) + int'(i_mask_wmax) && ey <= int'(i_mask_offy) + int'(i_mask_hmax);
          if (i_op_mask_mode == DSM_MASK_FULL) ok &= mf(ex[15:0], ey[15:0]);
          if (ok) q.push_back({ex[15:0], ey[15:0]});
          if (i < c[3:0]) begin
            ex += DX[c[7:5]];
            ey += DY[c[7:5]];
          end
        end
        st = c == DSM_STOP_CODE;
      end
    end
  endtask
  // load pointer, write step codes, spoil a busy run, wait for the end
  task automatic run(input logic [15:0] x, y, input logic [31:0] d, input logic [3:0] be, input logic [3:0] m);
    int n;
    @(posedge i_clk);
    i_ptr_ld <= 1;
    i_ptr_x <= x;
    i_ptr_y <= y;
    i_op_mask_mode <= m[1:0];
    i_op_draw_mode <= m[3:2];
    @(posedge i_clk);
    i_ptr_ld <= 0;
    ex = $signed(x);
    ey = $signed(y);
    if (i_op_func == DSM_FUNC_DRAW_STEP && be[3]) predict(d, be);
    i_step_wr <= 1;
    i_step_be <= be;
    i_step_data <= d;
    @(posedge i_clk);
    i_step_wr <= 0;
    if (be[0] && d[3:0] > 4'h2 && i_op_func == DSM_FUNC_DRAW_STEP) begin
      repeat (2) @(posedge i_clk);
      i_step_wr <= 1;
      i_step_data <= 32'h1F1F1F1F;
      i_ptr_ld <= 1;
      @(posedge i_clk);
      i_step_wr <= 0;
      i_ptr_ld <= 0;
    end
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_busy !== 1'b0 && n < 3000);
    check(o_busy, 1'b0);
    check({o_dst_x, o_dst_y}, {ex[15:0], ey[15:0]});
    check(q.size(), 0);
  endtask
  // pixel monitor takes the oldest expected update
  always @(posedge i_clk) if (o_pix_wr) check({o_pix_x, o_pix_y}, q.size() ? q.pop_front() : 32'hX);
  // mask memory responder with a random wait
  initial forever begin
    int xm, ym, off;
    @(posedge i_clk);
    if (o_mask_req) begin
      xm = $signed(o_dst_x) - int'(i_mask_offx);
      ym = $signed(o_dst_y) - int'(i_mask_offy);
      off = ym * (int'(i_mask_wmax) + 1) + xm;
      if (xm >= 0 && ym >= 0 && xm <= int'(i_mask_wmax) && ym <= int'(i_mask_hmax)) begin
        check(o_mask_addr, i_mask_base + (off >> 3));
        check(o_mask_bit, off & 7);
      end
      repeat (rnd() % 3) @(posedge i_clk);
      i_mask_ack <= 1;
      i_mask_val <= mf(o_dst_x, o_dst_y);
      @(posedge i_clk);
      i_mask_ack <= 0;
      @(posedge i_clk);
    end
  end
  // watchdog well past the expected run length
  initial begin
    #2500000;
    bad_count++;
    finish_test();
  end
  // main sequence
  initial begin
    logic [31:0] d;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1;
    run(16'h11, 16'hA, 32'h0000_0035, 4'hF, 4'h0);
    run(16'h5, 16'h5, 32'h0000_1212, 4'h7, 4'h0);
    run(16'h3, 16'h3, 32'h3535_3500, 4'hF, 4'h0);
    for (int k = 0; k < 24; k++) begin
      d = rnd();
      d[7:5] = k[2:0];
      if (k % 3 == 1) d[15:8] = 8'h00;
      run(16'(rnd() % 48 - 4), 16'(rnd() % 36 - 3), d, BE[rnd() % 4], {2'(k / 8), 2'(k % 4)});
    end
    @(posedge i_clk);
    i_op_func <= 4'h5;
    run(16'h8, 16'h8, 32'h3535_3535, 4'hF, 4'h0);
    finish_test();
  end
endmodule
